// ---- cuv_defs.vh ----
// Purpose: Constants for the comparator undervoltage threshold bank
// Assumes: AHB-Lite word registers, 100 MHz clock
// Notes:   Printed offsets are indices; byte address is four times index
//
// Functional notes
// - Thresholds read/write, 12-bit code in 15:4
// - Absolute aux UV threshold resets to zero
// - Aux scan below threshold sets aux alert
// - Absolute aux thresholds only when reference bit 1
// - Zero code never raises undervoltage alert
// - Cell open threshold resets to zero
// - Open-wire cell scan below threshold sets cell alert
// - Zero cell open code suppresses cell alerts
// - Ratiometric open scan below threshold sets aux alert
// - Ratiometric open threshold only when reference bit 0
// - Absolute open scan below threshold sets aux alert
`ifndef CUV_DEFS_VH
`define CUV_DEFS_VH

// ----------------------------------------
// Register indices
// ----------------------------------------
`define CUV_IDX_AUX_ABS_UV     8'h3D
`define CUV_IDX_CELL_OPEN      8'h3E
`define CUV_IDX_AUX_RATIO_OPEN 8'h3F
`define CUV_IDX_AUX_ABS_OPEN   8'h40
`define CUV_IDX_ALERT_STATUS   8'h50
`define CUV_IDX_ALERT_ENABLE   8'h51
`define CUV_IDX_ALERT_CLEAR    8'h52

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define CUV_LVL_MSB   15
`define CUV_LVL_LSB   4
`define CUV_LVL_RESET 12'h000
`define CUV_ALERT_AUX  0
`define CUV_ALERT_CELL 1

// ----------------------------------------
// Scan kinds
// ----------------------------------------
`define CUV_SCAN_NORMAL 1'b0
`define CUV_SCAN_OPEN   1'b1

`endif

// ---- cuv_level_mem.v ----
// Purpose: Four-entry threshold store with registered read
// Assumes: One write port, one read port, same clock
// Notes:   Read data lags address by one cycle
`timescale 1ns/100ps
`include "cuv_defs.vh"

module cuv_level_mem (
	input  wire        clock_i,
	input  wire        rstn_i,
	input  wire        wr_en_i,
	input  wire [1:0]  wr_addr_i,
	input  wire [11:0] wr_data_i,
	input  wire [1:0]  rd_addr_i,
	output reg  [11:0] rd_data_o,
	output wire [47:0] all_o
);
	reg [11:0] mem_q [0:3];
	integer    i;

	assign all_o = {mem_q[3], mem_q[2], mem_q[1], mem_q[0]};

	always @(posedge clock_i) begin
		if (!rstn_i) begin
			for (i = 0; i < 4; i = i + 1) begin
				mem_q[i] <= `CUV_LVL_RESET;
			end
			rd_data_o <= 12'h000;
		end else begin
			if (wr_en_i) begin
				mem_q[wr_addr_i] <= wr_data_i;
			end
			rd_data_o <= mem_q[rd_addr_i];
		end
	end
endmodule

// ---- cuv_compare.v ----
// Purpose: Undervoltage compare of one scan result
// Assumes: Inputs stable for the cycle
// Notes:   Registered hit output
`timescale 1ns/100ps

module cuv_compare (
	input  wire        clock_i,
	input  wire        rstn_i,
	input  wire        valid_i,
	input  wire [11:0] result_i,
	input  wire [11:0] level_i,
	output reg         hit_o
);
	always @(posedge clock_i) begin
		if (!rstn_i) begin
			hit_o <= 1'b0;
		end else begin
			// Zero code can never be undercut, so it disables the check
			hit_o <= valid_i && (level_i != 12'h000) && (result_i < level_i);
		end
	end
endmodule

// ---- cuv_bank.v ----
// Purpose: Comparator undervoltage threshold bank with AHB-Lite slave
// Assumes: Scan inputs are synchronous to clock_i
// Notes:   Alerts are sticky, cleared by write-one to clear register
//
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/100ps
`include "cuv_defs.vh"

module cuv_bank (
	input  wire        clock_i,
	input  wire        rstn_i,
	// AHB-Lite slave
	input  wire        hsel_i,
	input  wire [31:0] haddr_i,
	input  wire [1:0]  htrans_i,
	input  wire        hwrite_i,
	input  wire [2:0]  hsize_i,
	input  wire [31:0] hwdata_i,
	input  wire        hready_i,
	output reg  [31:0] hrdata_o,
	output reg         hreadyout_o,
	output reg         hresp_o,
	// Comparator scan
	input  wire        scan_valid_i,
	input  wire        scan_kind_i,
	input  wire        scan_is_aux_i,
	input  wire        aux_reference_select_i,
	input  wire        cell_open_diag_select_i,
	input  wire        aux_diag_select_i,
	input  wire [11:0] scan_result_i,
	// Alerts
	output reg         aux_comparator_uv_alert_o,
	output reg         cell_comparator_uv_alert_o,
	output reg         irq_o
);

	// ----------------------------------------
	// Functions
	// ----------------------------------------
	function [7:0] word_index;
		input [31:0] addr;
		begin
			word_index = addr[9:2];
		end
	endfunction

	function is_level_reg;
		input [7:0] idx;
		begin
			is_level_reg = (idx >= `CUV_IDX_AUX_ABS_UV) && (idx <= `CUV_IDX_AUX_ABS_OPEN);
		end
	endfunction

	// ----------------------------------------
	// Bus address phase capture
	// ----------------------------------------
	reg        wr_pend_q;
	reg        rd_pend_q;
	reg [7:0]  idx_q;
	wire       take;
	wire [7:0] cur_idx;

	assign take    = hsel_i && hready_i && htrans_i[1];
	assign cur_idx = word_index(haddr_i);

	always @(posedge clock_i) begin
		if (!rstn_i) begin
			wr_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
			idx_q     <= 8'h00;
		end else begin
			wr_pend_q <= take && hwrite_i;
			rd_pend_q <= take && !hwrite_i;
			if (take) begin
				idx_q <= cur_idx;
			end
		end
	end

	// ----------------------------------------
	// Threshold storage
	// ----------------------------------------
	wire [47:0] levels;
	wire [11:0] aux_abs_uv_level;
	wire [11:0] cell_open_uv_level;
	wire [11:0] aux_ratio_open_level;
	wire [11:0] aux_abs_open_level;
	wire        lvl_wr;

	assign lvl_wr = wr_pend_q && is_level_reg(idx_q);

	cuv_level_mem u_mem (
		.clock_i   (clock_i),
		.rstn_i    (rstn_i),
		.wr_en_i   (lvl_wr),
		.wr_addr_i (idx_q[1:0] - 2'd1),
		.wr_data_i (hwdata_i[`CUV_LVL_MSB:`CUV_LVL_LSB]),
		.rd_addr_i (cur_idx[1:0] - 2'd1),
		.rd_data_o (),
		.all_o     (levels)
	);

	assign aux_abs_uv_level     = levels[11:0];
	assign cell_open_uv_level   = levels[23:12];
	assign aux_ratio_open_level = levels[35:24];
	assign aux_abs_open_level   = levels[47:36];

	// ----------------------------------------
	// Threshold selection per scan
	// ----------------------------------------
	reg [11:0] aux_level;
	reg        aux_check;
	reg        cell_check;

	always @* begin
		aux_level  = 12'h000;
		aux_check  = 1'b0;
		cell_check = 1'b0;
		if (scan_valid_i && scan_is_aux_i) begin
			if (scan_kind_i == `CUV_SCAN_NORMAL) begin
				// Ratiometric normal threshold lives outside this bank
				aux_check = aux_reference_select_i;
				aux_level = aux_abs_uv_level;
			end else if (aux_diag_select_i) begin
				aux_check = 1'b1;
				if (aux_reference_select_i) begin
					aux_level = aux_abs_open_level;
				end else begin
					aux_level = aux_ratio_open_level;
				end
			end
		end
		if (scan_valid_i && !scan_is_aux_i && scan_kind_i == `CUV_SCAN_OPEN) begin
			cell_check = cell_open_diag_select_i;
		end
	end

	wire aux_hit;
	wire cell_hit;

	cuv_compare u_aux_cmp (
		.clock_i  (clock_i),
		.rstn_i   (rstn_i),
		.valid_i  (aux_check),
		.result_i (scan_result_i),
		.level_i  (aux_level),
		.hit_o    (aux_hit)
	);

	cuv_compare u_cell_cmp (
		.clock_i  (clock_i),
		.rstn_i   (rstn_i),
		.valid_i  (cell_check),
		.result_i (scan_result_i),
		.level_i  (cell_open_uv_level),
		.hit_o    (cell_hit)
	);

	// ----------------------------------------
	// Alert status, enable, clear
	// ----------------------------------------
	reg  [1:0] status_q;
	reg  [1:0] enable_q;
	wire [1:0] events;
	wire [1:0] clr;

	assign events = {cell_hit, aux_hit};
	assign clr    = (wr_pend_q && idx_q == `CUV_IDX_ALERT_CLEAR) ? hwdata_i[1:0] : 2'b00;

	always @(posedge clock_i) begin
		if (!rstn_i) begin
			status_q <= 2'b00;
			enable_q <= 2'b00;
		end else begin
			// Set wins over a clear in the same cycle
			status_q <= (status_q & ~clr) | events;
			if (wr_pend_q && idx_q == `CUV_IDX_ALERT_ENABLE) begin
				enable_q <= hwdata_i[1:0];
			end
		end
	end

	always @(posedge clock_i) begin
		if (!rstn_i) begin
			aux_comparator_uv_alert_o  <= 1'b0;
			cell_comparator_uv_alert_o <= 1'b0;
			irq_o                      <= 1'b0;
		end else begin
			aux_comparator_uv_alert_o  <= status_q[`CUV_ALERT_AUX];
			cell_comparator_uv_alert_o <= status_q[`CUV_ALERT_CELL];
			irq_o                      <= |(status_q & enable_q);
		end
	end

	// ----------------------------------------
	// Read data and response
	// ----------------------------------------
	reg [31:0] rdata_d;

	always @* begin
		rdata_d = 32'h0000_0000;
		if (take && !hwrite_i) begin
			if (is_level_reg(cur_idx)) begin
				// Flat copy keeps the read zero-wait with a registered output
				case (cur_idx[1:0])
					2'b01: begin
						rdata_d = {16'h0000, aux_abs_uv_level, 4'h0};
					end
					2'b10: begin
						rdata_d = {16'h0000, cell_open_uv_level, 4'h0};
					end
					2'b11: begin
						rdata_d = {16'h0000, aux_ratio_open_level, 4'h0};
					end
					default: begin
						rdata_d = {16'h0000, aux_abs_open_level, 4'h0};
					end
				endcase
			end else if (cur_idx == `CUV_IDX_ALERT_STATUS) begin
				rdata_d = {30'h0, status_q};
			end else if (cur_idx == `CUV_IDX_ALERT_ENABLE) begin
				rdata_d = {30'h0, enable_q};
			end
		end
	end

	// Read word registered at the address phase, stands in the data phase
	always @(posedge clock_i) begin
		if (!rstn_i) begin
			hrdata_o <= 32'h0000_0000;
		end else begin
			hrdata_o <= rdata_d;
		end
	end

	always @(posedge clock_i) begin
		if (!rstn_i) begin
			hreadyout_o <= 1'b1;
			hresp_o     <= 1'b0;
		end else begin
			hreadyout_o <= 1'b1;
			hresp_o     <= 1'b0;
		end
	end
endmodule

// ---- cuv_bank_properties.sv ----
// Purpose: Bus and alert properties of the threshold bank
// Assumes: Zero-wait slave, alert three edges after its scan
// Notes:   Sees top-level ports only
`timescale 1ns/100ps

module cuv_bank_props (
	input wire        clock_i,
	input wire        rstn_i,
	input wire        hsel_i,
	input wire [31:0] haddr_i,
	input wire [1:0]  htrans_i,
	input wire        hwrite_i,
	input wire        hready_i,
	input wire [31:0] hrdata_o,
	input wire        hreadyout_o,
	input wire        hresp_o,
	input wire        scan_valid_i,
	input wire        scan_kind_i,
	input wire        scan_is_aux_i,
	input wire        aux_reference_select_i,
	input wire        cell_open_diag_select_i,
	input wire        aux_diag_select_i,
	input wire        aux_comparator_uv_alert_o,
	input wire        cell_comparator_uv_alert_o
);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rstn_i);
	wire      req = hsel_i && hready_i && htrans_i[1];
	reg [2:0] clr_q;
	// Three stages so the exact clear-to-output lag does not matter
	always @(posedge clock_i) begin
		if (!rstn_i)
			clr_q <= 3'h0;
		else
			clr_q <= {clr_q[1:0], req && hwrite_i && haddr_i == 32'h148};
	end
	sequence s_thr_rd;
		req && !hwrite_i && haddr_i >= 32'hF4 && haddr_i <= 32'h100;
	endsequence
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	AST_READY: assert property (hreadyout_o && !hresp_o)
		else $error("slave not ready or not OKAY");
	AST_LOW_BITS: assert property (s_thr_rd |=> hrdata_o[3:0] == 4'h0)
		else $error("threshold low bits not zero");
	AST_HIGH_BITS: assert property (s_thr_rd |=> hrdata_o[31:16] == 16'h0000)
		else $error("threshold upper bits not zero");
	AST_AUX_CAUSE: assert property ($rose(aux_comparator_uv_alert_o)
		|-> $past(scan_valid_i && scan_is_aux_i, 3)) else $error("aux alert without scan");
	AST_ABS_ONLY: assert property ($rose(aux_comparator_uv_alert_o) && $past(!scan_kind_i, 3)
		|-> $past(aux_reference_select_i, 3)) else $error("normal alert on ratio channel");
	AST_OPEN_AUX: assert property ($rose(aux_comparator_uv_alert_o) && $past(scan_kind_i, 3)
		|-> $past(aux_diag_select_i, 3)) else $error("open aux alert unselected");
	AST_CELL_CAUSE: assert property ($rose(cell_comparator_uv_alert_o) |-> $past(scan_valid_i
		&& !scan_is_aux_i && scan_kind_i && cell_open_diag_select_i, 3))
		else $error("cell alert without open cell scan");
	AST_STICKY: assert property ($fell(aux_comparator_uv_alert_o)
		|| $fell(cell_comparator_uv_alert_o) |-> |clr_q) else $error("alert fell without clear");
endmodule

bind cuv_bank cuv_bank_props i_cuv_bank_props (.clock_i, .rstn_i, .hsel_i, .haddr_i,
	.htrans_i, .hwrite_i, .hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .scan_valid_i,
	.scan_kind_i, .scan_is_aux_i, .aux_reference_select_i, .cell_open_diag_select_i,
	.aux_diag_select_i, .aux_comparator_uv_alert_o, .cell_comparator_uv_alert_o);

// ---- cuv_bank_tb_top.sv ----
// Purpose: Self-checking bench for the threshold bank
// Assumes: Zero-wait AHB-Lite slave, fixed alert latency
// Notes:   Read data is checked against a queue by a monitor
`timescale 1ns/100ps

module cuv_bank_tb_top;
	reg         clock_i = 1'b0;
	reg         rstn_i = 1'b0;
	reg         hsel = 1'b0;
	reg  [31:0] haddr = 32'h0;
	reg  [1:0]  htrans = 2'h0;
	reg         hwrite = 1'b0;
	reg  [31:0] hwdata = 32'h0;
	reg         sv = 1'b0;
	reg  [4:0]  sk = 5'h00;
	reg  [11:0] sres = 12'h000;
	reg         rd_ph = 1'b0;
	reg  [1:0]  en = 2'h0;
	reg  [31:0] d;
	reg  [31:0] expq[$];
	integer     seed = 29673;
	integer     error_cnt = 0;
	integer     tests_run = 0;
	integer     i;
	wire [31:0] hrdata;
	wire        hready;
	wire        aux_al;
	wire        cell_al;
	wire        irq;

	always #5 clock_i = ~clock_i;

	cuv_bank i_cuv_bank (.clock_i(clock_i), .rstn_i(rstn_i), .hsel_i(hsel), .haddr_i(haddr),
		.htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
		.hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(),
		.scan_valid_i(sv), .scan_kind_i(sk[4]), .scan_is_aux_i(sk[3]),
		.aux_reference_select_i(sk[2]), .cell_open_diag_select_i(sk[1]),
		.aux_diag_select_i(sk[0]), .scan_result_i(sres), .aux_comparator_uv_alert_o(aux_al),
		.cell_comparator_uv_alert_o(cell_al), .irq_o(irq));

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task close_out;
		$display("checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task chk(input [8*8-1:0] what, input [31:0] e, input [31:0] s);
		tests_run = tests_run + 1;
		if (s !== e) begin
			$display("CHECK FAILED %0s expected %h seen %h", what, e, s);
			error_cnt = error_cnt + 1;
		end
	endtask
	task wait_rdy;
		integer n;
		n = 0;
		@(posedge clock_i);
		while (hready !== 1'b1) begin
			n = n + 1;
			if (n > 20) begin
				error_cnt = error_cnt + 1;
				close_out;
			end
			@(posedge clock_i);
		end
	endtask
	task ahb(input [31:0] a, input w, input [31:0] wd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		wait_rdy;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy;
	endtask
	task rd(input [31:0] a, input [31:0] e);
		expq.push_back(e);
		ahb(a, 1'b0, 32'h0);
	endtask
	// Scan, then alert pins, irq and status after the fixed latency
	task sc(input [4:0] k, input [11:0] r, input [1:0] e);
		sv <= 1'b1;
		sk <= k;
		sres <= r;
		@(posedge clock_i);
		sv <= 1'b0;
		repeat (3) @(posedge clock_i);
		#1;
		chk("alerts", {30'h0, e}, {30'h0, cell_al, aux_al});
		chk("irq", {31'h0, |(e & en)}, {31'h0, irq});
		@(posedge clock_i);
		rd(32'h140, {30'h0, e});
		ahb(32'h148, 1'b1, 32'h3);
	endtask

	// Read data phase: oldest note against hrdata
	always @(posedge clock_i) begin
		if (rd_ph && hready === 1'b1)
			chk("hrdata", expq.pop_front(), hrdata);
		rd_ph <= hsel && htrans[1] && !hwrite && hready;
	end

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		repeat (2) @(posedge clock_i);
		rstn_i <= 1'b1;
		for (i = 0; i < 4; i = i + 1)
			rd(32'hF4 + 4 * i, 32'h0);
		rd(32'h144, 32'h0);
		// Last pass hits an unmapped word
		for (i = 0; i < 5; i = i + 1) begin
			d = $random(seed);
			ahb(32'hF4 + 4 * i, 1'b1, d);
			rd(32'hF4 + 4 * i, i < 4 ? {16'h0, d[15:4], 4'h0} : 32'h0);
		end
		// Levels kept low so they stay under any OV level
		ahb(32'hF4, 1'b1, 32'h1000);
		ahb(32'hF8, 1'b1, 32'h3000);
		ahb(32'hFC, 1'b1, 32'h2000);
		ahb(32'h100, 1'b1, 32'h0800);
		sc(5'h0C, 12'h0FF, 2'h1);
		ahb(32'h144, 1'b1, 32'h3);
		en = 2'h3;
		rd(32'h144, 32'h3);
		sc(5'h0C, 12'h0FF, 2'h1);
		sc(5'h0C, 12'h100, 2'h0);
		sc(5'h08, 12'h000, 2'h0);
		sc(5'h12, 12'h2FF, 2'h2);
		sc(5'h10, 12'h000, 2'h0);
		sc(5'h19, 12'h100, 2'h1);
		sc(5'h18, 12'h000, 2'h0);
		sc(5'h1D, 12'h07F, 2'h1);
		sc(5'h1D, 12'h100, 2'h0);
		for (i = 0; i < 4; i = i + 1)
			ahb(32'hF4 + 4 * i, 1'b1, 32'h0);
		sc(5'h0C, 12'h000, 2'h0);
		sc(5'h12, 12'h000, 2'h0);
		sc(5'h19, 12'h000, 2'h0);
		sc(5'h1D, 12'h000, 2'h0);
		close_out;
	end
endmodule
